// >>> rtl/dsac_params.svh
// Constants of the data space address checker
`ifndef DSAC_PARAMS_SVH
`define DSAC_PARAMS_SVH

// Start of data RAM; everything below is the register area
`define DSAC_RAM_BASE 16'h0800
// Stack pointer value after reset
`define DSAC_SP_RESET 16'h0800
// Default Y region bounds and top of implemented memory
`define DSAC_Y_BASE 16'h1800
`define DSAC_Y_END 16'h27FF
`define DSAC_MEM_TOP 16'h27FF
// Near space reach of the 13-bit absolute field
`define DSAC_NEAR_MASK 16'h1FFF
// Pointer steps for byte and word operands
`define DSAC_STEP_BYTE 16'h0001
`define DSAC_STEP_WORD 16'h0002
// Word-align mask for stack pointer and limit
`define DSAC_ALIGN_MASK 16'hFFFE
// Value returned by invalid reads
`define DSAC_ZERO_WORD 16'h0000
`define DSAC_ZERO_BYTE 8'h00

`endif

// >>> rtl/dsac_pkg.sv
// Types shared by the data space address checker
package dsac_pkg;

	typedef enum logic [1:0] {
		AM_PLAIN = 2'b00,
		AM_POSTINC = 2'b01,
		AM_MODULO = 2'b10,
		AM_BITREV = 2'b11
	} dsac_mode_t;

	typedef enum logic [2:0] {
		SRC_PTR = 3'b000,
		SRC_NEAR = 3'b001,
		SRC_DIRECT = 3'b010,
		SRC_PUSH = 3'b011,
		SRC_POP = 3'b100,
		SRC_ACC_WB = 3'b101
	} dsac_src_t;

	typedef enum logic [2:0] {
		PTR_OTHER = 3'b000,
		PTR_XA = 3'b001,
		PTR_XB = 3'b010,
		PTR_YA = 3'b011,
		PTR_YB = 3'b100,
		PTR_SP = 3'b101
	} dsac_ptr_t;

endpackage

// >>> rtl/dsac_ifs.sv
// Interfaces between the checker top and its pointer and stack helpers
`timescale 1ns/1ns
interface dsac_agu_if;
	import dsac_pkg::*;
	logic [15:0] ptr;
	logic [15:0] mod_start;
	logic [15:0] mod_end;
	logic [15:0] brev_inc;
	logic byte_op;
	logic brev_en;
	dsac_mode_t mode;
	logic [15:0] next_ptr;
	modport agu (input ptr, mod_start, mod_end, brev_inc, byte_op, brev_en, mode, output next_ptr);
	modport user (output ptr, mod_start, mod_end, brev_inc, byte_op, brev_en, mode, input next_ptr);
endinterface

interface dsac_stk_if;
	logic [15:0] ea;
	logic [15:0] limit;
	logic push;
	logic sp_src;
	logic limit_err;
	logic under_err;
	modport chk (input ea, limit, push, sp_src, output limit_err, under_err);
	modport user (output ea, limit, push, sp_src, input limit_err, under_err);
endinterface

// >>> rtl/dsac_agu.sv
// Pointer post-modify unit: linear, modulo and bit-reversed stepping
`timescale 1ns/1ns
`include "dsac_params.svh"
module dsac_agu
	import dsac_pkg::*;
(
	dsac_agu_if.agu a
);
	logic [15:0] step;
	logic [15:0] inc;
	logic [15:0] rev_ptr;
	logic [15:0] rev_inc;
	logic [15:0] rev_sum;
	logic [15:0] brev_next;

	assign step = a.byte_op ? `DSAC_STEP_BYTE : `DSAC_STEP_WORD;
	assign inc = a.ptr + step;

	// Reverse-carry add: add in mirrored bit order, then mirror back
	genvar i;
	generate
		for (i = 0; i < 16; i++)
		begin : g_rev
			assign rev_ptr[i] = a.ptr[15 - i];
			assign rev_inc[i] = a.brev_inc[15 - i];
			assign brev_next[i] = rev_sum[15 - i];
		end
	endgenerate
	assign rev_sum = rev_ptr + rev_inc;

	always_comb
	begin
		unique case (a.mode)
			AM_PLAIN: a.next_ptr = a.ptr;
			AM_POSTINC: a.next_ptr = inc;
			// Wrap when the last element of the buffer has been used
			AM_MODULO: a.next_ptr = (a.ptr >= a.mod_end) ? a.mod_start : inc;
			// Without permission bit-reverse falls back to a plain step
			AM_BITREV: a.next_ptr = a.brev_en ? brev_next : inc;
		endcase
	end
endmodule

// >>> rtl/dsac_stack_chk.sv
// Stack limit and underflow comparison on stack-pointer addresses
`timescale 1ns/1ns
`include "dsac_params.svh"
module dsac_stack_chk
#(
	parameter logic [15:0] RAM_BASE = `DSAC_RAM_BASE
)
(
	dsac_stk_if.chk s
);
	// Equal to the limit is still legal; only beyond it traps
	assign s.limit_err = s.sp_src && s.push && (s.ea > s.limit);
	assign s.under_err = s.sp_src && (s.ea < RAM_BASE);
endmodule

// >>> rtl/dsac_top.sv
// Data space address checker: X/Y decode, alignment, byte lanes, stack checks
`timescale 1ns/1ns
`include "dsac_params.svh"
module dsac_top
	import dsac_pkg::*;
#(
	parameter logic [15:0] Y_BASE = `DSAC_Y_BASE,
	parameter logic [15:0] Y_END = `DSAC_Y_END,
	parameter logic [15:0] MEM_TOP = `DSAC_MEM_TOP,
	parameter logic [15:0] RAM_BASE = `DSAC_RAM_BASE
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic x_valid,
	input wire logic x_write,
	input wire logic x_byte,
	input wire logic x_mac,
	input wire dsac_src_t x_src,
	input wire dsac_ptr_t x_ptr_sel,
	input wire dsac_mode_t x_mode,
	input wire logic [15:0] x_ptr,
	input wire logic [15:0] x_dir,
	input wire logic [15:0] x_wdata,
	input wire logic x_pc_push,
	input wire logic x_exc_push,
	input wire logic [7:0] status_low_byte,
	input wire logic y_valid,
	input wire dsac_mode_t y_mode,
	input wire logic [15:0] y_ptr,
	input wire logic [15:0] mod_start,
	input wire logic [15:0] mod_end,
	input wire logic [15:0] brev_inc,
	input wire logic sp_wr,
	input wire logic [15:0] sp_wdata,
	input wire logic stack_limit_reg_wr,
	input wire logic [15:0] stack_limit_reg_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic [15:0] y_mem_rdata,
	output logic [14:0] mem_addr,
	output logic mem_re,
	output logic mem_we_lo,
	output logic mem_we_hi,
	output logic [15:0] mem_wdata,
	output logic [14:0] y_mem_addr,
	output logic y_mem_re,
	output logic [15:0] x_rdata,
	output logic x_rvalid,
	output logic x_load_we_lo,
	output logic x_load_we_hi,
	output logic [15:0] y_rdata,
	output logic y_rvalid,
	output logic [15:0] x_ea,
	output logic [15:0] x_next_ptr,
	output logic x_ptr_upd,
	output logic [15:0] y_next_ptr,
	output logic y_ptr_upd,
	output logic [15:0] stack_pointer_reg,
	output logic [15:0] stack_limit_reg,
	output logic addr_err_trap,
	output logic stack_err_trap,
	output logic [15:0] trap_addr
);
	dsac_agu_if xagu();
	dsac_agu_if yagu();
	dsac_stk_if stk();

	logic [15:0] x_ea_c;
	logic [14:0] x_word;
	logic x_in_y;
	logic x_unimpl;
	logic x_pref;
	logic x_zero;
	logic x_mis;
	logic x_rd;
	logic x_wr_ok;
	logic [15:0] x_word_data;
	logic y_go;
	logic y_in_y;
	logic y_zero;
	logic y_mis;
	logic s1_x_rd;
	logic s1_x_zero;
	logic s1_x_byte;
	logic s1_x_lsb;
	logic s1_y_rd;
	logic s1_y_zero;

	// Effective address for the X path
	always_comb
	begin
		unique case (x_src)
			SRC_NEAR: x_ea_c = x_dir & `DSAC_NEAR_MASK;
			SRC_DIRECT: x_ea_c = x_dir;
			SRC_PUSH: x_ea_c = stack_pointer_reg;
			SRC_POP: x_ea_c = stack_pointer_reg - `DSAC_STEP_WORD;
			// Pointer modes and accumulator write-back use the pointer as is
			default: x_ea_c = x_ptr;
		endcase
	end

	assign x_word = x_ea_c[15:1];
	assign x_in_y = (x_ea_c >= Y_BASE) && (x_ea_c <= Y_END);
	assign x_unimpl = x_ea_c > MEM_TOP;
	// Only MAC operand prefetch through the X pointers loses the Y block
	assign x_pref = x_mac && !x_write && (x_src == SRC_PTR) && ((x_ptr_sel == PTR_XA) || (x_ptr_sel == PTR_XB));
	assign x_zero = x_unimpl || (x_pref && x_in_y);
	assign x_mis = !x_byte && x_ea_c[0];
	assign x_rd = x_valid && !x_write;
	assign x_wr_ok = x_valid && x_write && !x_mis && !x_unimpl;

	// Calls clear the PC high byte; exceptions save the status byte there
	always_comb
	begin
		x_word_data = x_wdata;
		if (x_pc_push)
		begin
			x_word_data = {x_exc_push ? status_low_byte : `DSAC_ZERO_BYTE, x_wdata[7:0]};
		end
	end

	// Y path exists only beside a MAC prefetch
	assign y_go = y_valid && x_valid && x_mac && !x_write;
	assign y_in_y = (y_ptr >= Y_BASE) && (y_ptr <= Y_END);
	assign y_zero = !y_in_y || (y_ptr > MEM_TOP);
	assign y_mis = y_ptr[0];

	// X pointer unit may bit-reverse only on writes
	assign xagu.ptr = x_ptr;
	assign xagu.mod_start = mod_start;
	assign xagu.mod_end = mod_end;
	assign xagu.brev_inc = brev_inc;
	assign xagu.byte_op = x_byte;
	assign xagu.brev_en = x_write;
	assign xagu.mode = x_mode;
	dsac_agu u_xagu (
		.a(xagu)
	);

	// Y pointer unit: word-only, modulo allowed, never bit-reversed
	assign yagu.ptr = y_ptr;
	assign yagu.mod_start = mod_start;
	assign yagu.mod_end = mod_end;
	assign yagu.brev_inc = brev_inc;
	assign yagu.byte_op = 1'b0;
	assign yagu.brev_en = 1'b0;
	assign yagu.mode = y_mode;
	dsac_agu u_yagu (
		.a(yagu)
	);

	assign stk.ea = x_ea_c;
	assign stk.limit = stack_limit_reg;
	assign stk.push = x_src == SRC_PUSH;
	assign stk.sp_src = (x_src == SRC_PUSH) || (x_src == SRC_POP) || ((x_src == SRC_PTR) && (x_ptr_sel == PTR_SP));
	dsac_stack_chk #(
		.RAM_BASE(RAM_BASE)
	) u_stk (
		.s(stk)
	);

	// X memory request stage
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			mem_addr <= '0;
			mem_re <= 1'b0;
			mem_we_lo <= 1'b0;
			mem_we_hi <= 1'b0;
			mem_wdata <= `DSAC_ZERO_WORD;
		end
		else
		begin
			mem_addr <= x_word;
			mem_re <= x_rd && !x_zero;
			// One word decode, one strobe per byte lane
			mem_we_lo <= x_wr_ok && (!x_byte || !x_ea_c[0]);
			mem_we_hi <= x_wr_ok && (!x_byte || x_ea_c[0]);
			mem_wdata <= x_byte ? {x_wdata[7:0], x_wdata[7:0]} : x_word_data;
		end
	end

	// Y memory request stage; the Y bus has no write strobe at all
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			y_mem_addr <= '0;
			y_mem_re <= 1'b0;
		end
		else
		begin
			y_mem_addr <= y_ptr[15:1];
			y_mem_re <= y_go && !y_zero;
		end
	end

	// Read attributes carried to the return stage
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			s1_x_rd <= 1'b0;
			s1_x_zero <= 1'b0;
			s1_x_byte <= 1'b0;
			s1_x_lsb <= 1'b0;
			s1_y_rd <= 1'b0;
			s1_y_zero <= 1'b0;
		end
		else
		begin
			s1_x_rd <= x_rd;
			s1_x_zero <= x_zero;
			s1_x_byte <= x_byte;
			s1_x_lsb <= x_ea_c[0];
			s1_y_rd <= y_go;
			s1_y_zero <= y_zero;
		end
	end

	// Read return: zero for invalid, byte steered to the low lane
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			x_rdata <= `DSAC_ZERO_WORD;
			x_rvalid <= 1'b0;
			x_load_we_lo <= 1'b0;
			x_load_we_hi <= 1'b0;
		end
		else
		begin
			x_rvalid <= s1_x_rd;
			x_load_we_lo <= s1_x_rd;
			x_load_we_hi <= s1_x_rd && !s1_x_byte;
			if (s1_x_zero)
			begin
				x_rdata <= `DSAC_ZERO_WORD;
			end
			else if (s1_x_byte)
			begin
				x_rdata <= {`DSAC_ZERO_BYTE, s1_x_lsb ? mem_rdata[15:8] : mem_rdata[7:0]};
			end
			else
			begin
				x_rdata <= mem_rdata;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			y_rdata <= `DSAC_ZERO_WORD;
			y_rvalid <= 1'b0;
		end
		else
		begin
			y_rvalid <= s1_y_rd;
			y_rdata <= s1_y_zero ? `DSAC_ZERO_WORD : y_mem_rdata;
		end
	end

	// Pointer post-modify results for the core's register file
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			x_ea <= `DSAC_ZERO_WORD;
			x_next_ptr <= `DSAC_ZERO_WORD;
			x_ptr_upd <= 1'b0;
			y_next_ptr <= `DSAC_ZERO_WORD;
			y_ptr_upd <= 1'b0;
		end
		else
		begin
			x_ea <= x_ea_c;
			x_next_ptr <= xagu.next_ptr;
			x_ptr_upd <= x_valid && (x_src == SRC_PTR) && (x_mode != AM_PLAIN);
			y_next_ptr <= yagu.next_ptr;
			y_ptr_upd <= y_go && (y_mode != AM_PLAIN);
		end
	end

	// Stack pointer: word aligned, post-increment push, pre-decrement pop
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			stack_pointer_reg <= `DSAC_SP_RESET;
		end
		else if (sp_wr)
		begin
			stack_pointer_reg <= sp_wdata & `DSAC_ALIGN_MASK;
		end
		else if (x_valid && (x_src == SRC_PUSH))
		begin
			stack_pointer_reg <= stack_pointer_reg + `DSAC_STEP_WORD;
		end
		else if (x_valid && (x_src == SRC_POP))
		begin
			stack_pointer_reg <= stack_pointer_reg - `DSAC_STEP_WORD;
		end
	end

	// Deliberately not reset; the new limit is used from the next cycle,
	// so the core keeps a stack access out of the cycle in which the limit is written
	always_ff @(posedge clk)
	begin
		if (stack_limit_reg_wr)
		begin
			stack_limit_reg <= stack_limit_reg_wdata & `DSAC_ALIGN_MASK;
		end
	end

	// Trap requests, one cycle each, with the faulting address
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			addr_err_trap <= 1'b0;
			stack_err_trap <= 1'b0;
			trap_addr <= `DSAC_ZERO_WORD;
		end
		else
		begin
			addr_err_trap <= (x_valid && x_mis) || (y_go && y_mis);
			stack_err_trap <= x_valid && (stk.limit_err || stk.under_err);
			if (x_valid && (x_mis || stk.limit_err || stk.under_err))
			begin
				trap_addr <= x_ea_c;
			end
			else if (y_go && y_mis)
			begin
				trap_addr <= y_ptr;
			end
		end
	end

	a_x_excl_y: assert property (@(posedge clk) disable iff (reset)
		(x_valid && x_pref && x_in_y) |-> ##2 (x_rvalid && (x_rdata == `DSAC_ZERO_WORD)))
		else $error("X prefetch into Y did not return zero");

	a_linear_x: assert property (@(posedge clk) disable iff (reset)
		(x_rd && !x_mac && !x_unimpl) |=> (mem_re && (mem_addr == $past(x_word))))
		else $error("Non-MAC read not issued on the linear X path");

	a_y_only_mac: assert property (@(posedge clk) disable iff (reset)
		y_mem_re |-> $past(x_valid && x_mac && !x_write))
		else $error("Y read issued outside a MAC prefetch");

	a_acc_wb_x: assert property (@(posedge clk) disable iff (reset)
		(x_valid && x_write && (x_src == SRC_ACC_WB) && !x_byte && !x_ea_c[0] && !x_unimpl)
		|=> (mem_we_lo && mem_we_hi && (mem_addr == $past(x_word))))
		else $error("Accumulator write-back not written over X");

	a_y_no_brev: assert property (@(posedge clk) disable iff (reset)
		(y_go && (y_mode == AM_BITREV)) |=> (y_next_ptr == $past(y_ptr) + `DSAC_STEP_WORD))
		else $error("Y pointer was bit-reversed");

	a_y_zero_x: assert property (@(posedge clk) disable iff (reset)
		(y_go && !y_in_y) |-> ##2 (y_rvalid && (y_rdata == `DSAC_ZERO_WORD)))
		else $error("Y pointer into X did not return zero");

	a_byte_lane: assert property (@(posedge clk) disable iff (reset)
		(x_rd && x_byte) |-> ##2 ((x_rdata[15:8] == `DSAC_ZERO_BYTE) && x_load_we_lo && !x_load_we_hi))
		else $error("Byte read not placed in the low lane");

	a_byte_strobe: assert property (@(posedge clk) disable iff (reset)
		(x_valid && x_write && x_byte) |=> !(mem_we_lo && mem_we_hi))
		else $error("Byte write drove both lanes");

	a_misalign: assert property (@(posedge clk) disable iff (reset)
		(x_valid && x_mis) |=> (addr_err_trap && !mem_we_lo && !mem_we_hi && (trap_addr == $past(x_ea_c))))
		else $error("Odd word access not trapped or write not suppressed");

	a_pc_push: assert property (@(posedge clk) disable iff (reset)
		(x_wr_ok && x_pc_push && !x_byte) |=> (mem_wdata[15:8] == $past(x_exc_push ? status_low_byte : `DSAC_ZERO_BYTE)))
		else $error("Pushed PC high byte wrong");

	a_sp_push: assert property (@(posedge clk) disable iff (reset)
		(x_valid && (x_src == SRC_PUSH) && !sp_wr) |=> (stack_pointer_reg == $past(stack_pointer_reg) + `DSAC_STEP_WORD))
		else $error("Push did not advance stack pointer by a word");

	a_limit_equal: assert property (@(posedge clk) disable iff (reset)
		(x_valid && (x_src == SRC_PUSH) && (stack_pointer_reg == stack_limit_reg) && (stack_pointer_reg >= RAM_BASE))
		|=> !stack_err_trap)
		else $error("Push at the limit trapped");

	a_limit_over: assert property (@(posedge clk) disable iff (reset)
		(x_valid && (x_src == SRC_PUSH) && (stack_pointer_reg > stack_limit_reg)) |=> stack_err_trap)
		else $error("Push beyond the limit did not trap");

	a_underflow: assert property (@(posedge clk) disable iff (reset)
		(x_valid && (x_src == SRC_POP) && (x_ea_c < RAM_BASE)) |=> (stack_err_trap && (trap_addr == $past(x_ea_c))))
		else $error("Stack underflow not trapped");
endmodule

// >>> verif/dsac_mem_model.sv
// Data memory model answering the checker's X and Y read ports
`timescale 1ns/1ns
module dsac_mem_model
(
	input wire logic clk,
	input wire logic [14:0] mem_addr,
	input wire logic mem_re,
	input wire logic mem_we_lo,
	input wire logic mem_we_hi,
	input wire logic [15:0] mem_wdata,
	input wire logic [14:0] y_mem_addr,
	input wire logic y_mem_re,
	output logic [15:0] mem_rdata,
	output logic [15:0] y_mem_rdata
);
	logic [15:0] mem [0:32767];
	// Idle pattern differs from every word the bench stores
	logic [15:0] junk = 16'h3C3C;
	// Lanes are written apart so a byte store leaves its neighbour alone
	always @(posedge clk)
	begin
		if (mem_we_lo)
			mem[mem_addr][7:0] <= mem_wdata[7:0];
		if (mem_we_hi)
			mem[mem_addr][15:8] <= mem_wdata[15:8];
		junk <= ~junk;
	end
	// Unselected ports show a toggling pattern, never a stale word
	assign mem_rdata = mem_re ? mem[mem_addr] : junk;
	assign y_mem_rdata = y_mem_re ? mem[y_mem_addr] : ~junk;
endmodule

// >>> verif/dsac_top_tb.sv
// Self-checking bench for the data space address checker
`timescale 1ns/1ns
module dsac_top_tb;
	import dsac_pkg::*;
	logic clk = 0, reset = 1, x_valid = 0, x_write = 0, x_byte = 0, x_mac = 0;
	dsac_src_t x_src = SRC_PTR;
	dsac_ptr_t x_ptr_sel = PTR_OTHER;
	dsac_mode_t x_mode = AM_PLAIN, y_mode = AM_PLAIN;
	logic [15:0] x_ptr = 0, x_dir = 0, x_wdata = 0, y_ptr = 0, mod_start = 0, mod_end = 0, brev_inc = 0;
	logic x_pc_push = 0, x_exc_push = 0, y_valid = 0, sp_wr = 0, stack_limit_reg_wr = 0;
	logic [7:0] status_low_byte = 0;
	logic [15:0] sp_wdata = 0, stack_limit_reg_wdata = 0, mem_rdata, y_mem_rdata, mem_wdata, x_rdata, y_rdata, x_ea;
	logic [15:0] x_next_ptr, y_next_ptr, stack_pointer_reg, stack_limit_reg, trap_addr;
	logic [14:0] mem_addr, y_mem_addr;
	logic mem_re, mem_we_lo, mem_we_hi, y_mem_re, x_rvalid, x_load_we_lo, x_load_we_hi, y_rvalid;
	logic x_ptr_upd, y_ptr_upd, addr_err_trap, stack_err_trap;
	int err_total = 0, num_checks = 0;

	dsac_top i_dsac_top (.clk(clk), .reset(reset), .x_valid(x_valid), .x_write(x_write), .x_byte(x_byte),
		.x_mac(x_mac), .x_src(x_src), .x_ptr_sel(x_ptr_sel), .x_mode(x_mode), .x_ptr(x_ptr), .x_dir(x_dir),
		.x_wdata(x_wdata), .x_pc_push(x_pc_push), .x_exc_push(x_exc_push), .status_low_byte(status_low_byte),
		.y_valid(y_valid), .y_mode(y_mode), .y_ptr(y_ptr), .mod_start(mod_start), .mod_end(mod_end),
		.brev_inc(brev_inc), .sp_wr(sp_wr), .sp_wdata(sp_wdata), .stack_limit_reg_wr(stack_limit_reg_wr), .stack_limit_reg_wdata(stack_limit_reg_wdata),
		.mem_rdata(mem_rdata), .y_mem_rdata(y_mem_rdata), .mem_addr(mem_addr), .mem_re(mem_re),
		.mem_we_lo(mem_we_lo), .mem_we_hi(mem_we_hi), .mem_wdata(mem_wdata), .y_mem_addr(y_mem_addr),
		.y_mem_re(y_mem_re), .x_rdata(x_rdata), .x_rvalid(x_rvalid), .x_load_we_lo(x_load_we_lo),
		.x_load_we_hi(x_load_we_hi), .y_rdata(y_rdata), .y_rvalid(y_rvalid), .x_ea(x_ea),
		.x_next_ptr(x_next_ptr), .x_ptr_upd(x_ptr_upd), .y_next_ptr(y_next_ptr), .y_ptr_upd(y_ptr_upd),
		.stack_pointer_reg(stack_pointer_reg), .stack_limit_reg(stack_limit_reg),
		.addr_err_trap(addr_err_trap), .stack_err_trap(stack_err_trap), .trap_addr(trap_addr));

	dsac_mem_model i_dsac_mem_model (.clk(clk), .mem_addr(mem_addr), .mem_re(mem_re), .mem_we_lo(mem_we_lo),
		.mem_we_hi(mem_we_hi), .mem_wdata(mem_wdata), .y_mem_addr(y_mem_addr), .y_mem_re(y_mem_re),
		.mem_rdata(mem_rdata), .y_mem_rdata(y_mem_rdata));

	initial
	begin
		forever #2 clk = ~clk;
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic xset(input logic wr, input logic byt, input logic mac, input dsac_src_t src,
		input dsac_ptr_t sel, input dsac_mode_t mode, input logic [15:0] ptr);
		x_write = wr;
		x_byte = byt;
		x_mac = mac;
		x_src = src;
		x_ptr_sel = sel;
		x_mode = mode;
		x_ptr = ptr;
	endtask

	// Presents one request for one edge; valid stays up so back-to-back calls never glitch it
	task automatic go(input logic v);
		x_valid = v;
		@(negedge clk);
	endtask

	// Drops every request and lets one edge pass
	task automatic idle;
		x_valid = 0;
		y_valid = 0;
		sp_wr = 0;
		stack_limit_reg_wr = 0;
		@(negedge clk);
	endtask

	// EA given both as pointer and as direct field, whichever the source uses
	task automatic wr(input dsac_src_t src, input logic [15:0] a, input logic byt, input logic [15:0] d);
		xset(1, byt, 0, src, PTR_OTHER, AM_PLAIN, a);
		x_dir = a;
		x_wdata = d;
		go(1);
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		xset(0, 0, 0, SRC_PTR, PTR_OTHER, AM_PLAIN, a);
		go(1);
		idle();
		chk("x_rdata", x_rdata, exp);
	endtask

	task automatic t_word_byte;
		wr(SRC_DIRECT, 16'h0900, 0, 16'h1234);
		chk("mem_addr", mem_addr, 15'h0480);
		chk("we", {mem_we_hi, mem_we_lo}, 2'b11);
		xset(0, 0, 0, SRC_PTR, PTR_OTHER, AM_POSTINC, 16'h0900);
		go(1);
		chk("x_next_ptr", x_next_ptr, 16'h0902);
		chk("x_ptr_upd", x_ptr_upd, 1'b1);
		idle();
		chk("x_rdata", x_rdata, 16'h1234);
		wr(SRC_DIRECT, 16'h0901, 1, 16'h00AB);
		chk("we", {mem_we_hi, mem_we_lo}, 2'b10);
		chk("mem_wdata", mem_wdata[15:8], 8'hAB);
		xset(0, 1, 0, SRC_PTR, PTR_OTHER, AM_POSTINC, 16'h0901);
		go(1);
		chk("x_next_ptr", x_next_ptr, 16'h0902);
		idle();
		chk("x_rdata", x_rdata, 16'h00AB);
		chk("load_we", {x_load_we_hi, x_load_we_lo}, 2'b01);
		rd(16'h0900, 16'hAB34);
	endtask

	task automatic t_align;
		wr(SRC_DIRECT, 16'h0901, 0, 16'hFFFF);
		chk("we", {mem_we_hi, mem_we_lo}, 2'b00);
		chk("addr_err_trap", addr_err_trap, 1'b1);
		chk("trap_addr", trap_addr, 16'h0901);
		xset(0, 0, 0, SRC_PTR, PTR_OTHER, AM_PLAIN, 16'h0905);
		go(1);
		chk("addr_err_trap", addr_err_trap, 1'b1);
		idle();
		chk("addr_err_trap", addr_err_trap, 1'b0);
		chk("x_rvalid", x_rvalid, 1'b1);
		rd(16'h0900, 16'hAB34);
	endtask

	task automatic mac(input dsac_ptr_t sel, input logic [15:0] xp, input logic [15:0] yp);
		xset(0, 0, 1, SRC_PTR, sel, AM_PLAIN, xp);
		y_valid = 1;
		y_ptr = yp;
		go(1);
	endtask

	task automatic t_spaces;
		wr(SRC_ACC_WB, 16'h1800, 0, 16'h5A5A);
		chk("we", {mem_we_hi, mem_we_lo}, 2'b11);
		y_mode = AM_POSTINC;
		mac(PTR_XA, 16'h0900, 16'h1800);
		chk("mem_re", {mem_re, y_mem_re}, 2'b11);
		chk("y_mem_addr", y_mem_addr, 15'h0C00);
		chk("y_next_ptr", y_next_ptr, 16'h1802);
		idle();
		chk("x_rdata", x_rdata, 16'hAB34);
		chk("y_rdata", y_rdata, 16'h5A5A);
		chk("y_rvalid", y_rvalid, 1'b1);
		mac(PTR_XB, 16'h1800, 16'h0900);
		chk("y_mem_re", y_mem_re, 1'b0);
		idle();
		chk("x_rdata", x_rdata, 16'h0000);
		chk("y_rdata", y_rdata, 16'h0000);
		rd(16'h1800, 16'h5A5A);
		xset(0, 0, 0, SRC_PTR, PTR_OTHER, AM_PLAIN, 16'h0900);
		y_valid = 1;
		go(1);
		chk("y_mem_re", y_mem_re, 1'b0);
		rd(16'h3000, 16'h0000);
		chk("x_rvalid", x_rvalid, 1'b1);
		xset(0, 0, 0, SRC_NEAR, PTR_OTHER, AM_PLAIN, 16'h0000);
		x_dir = 16'hE900;
		go(1);
		chk("x_ea", x_ea, 16'h0900);
		xset(0, 0, 0, SRC_DIRECT, PTR_OTHER, AM_PLAIN, 16'h0000);
		x_dir = 16'h1800;
		go(1);
		chk("x_ea", x_ea, 16'h1800);
		idle();
		chk("x_rdata", x_rdata, 16'h5A5A);
	endtask

	task automatic t_modes;
		mod_start = 16'h1800;
		mod_end = 16'h1806;
		y_mode = AM_MODULO;
		mac(PTR_XA, 16'h0906, 16'h1806);
		chk("y_next_ptr", y_next_ptr, 16'h1800);
		mod_start = 16'h0900;
		mod_end = 16'h0906;
		xset(0, 0, 0, SRC_PTR, PTR_OTHER, AM_MODULO, 16'h0906);
		go(1);
		chk("x_next_ptr", x_next_ptr, 16'h0900);
		brev_inc = 16'h0008;
		xset(0, 0, 0, SRC_PTR, PTR_OTHER, AM_BITREV, 16'h0908);
		go(1);
		chk("x_next_ptr", x_next_ptr, 16'h090A);
		// Reverse-carry add of 8 onto 0x0908 clears bit 3 and carries into bit 2
		xset(1, 0, 0, SRC_PTR, PTR_OTHER, AM_BITREV, 16'h0908);
		go(1);
		chk("x_next_ptr", x_next_ptr, 16'h0904);
		// Y steps linearly even when bit-reverse is asked for
		y_mode = AM_BITREV;
		mac(PTR_XA, 16'h0900, 16'h1808);
		chk("y_next_ptr", y_next_ptr, 16'h180A);
		chk("y_ptr_upd", y_ptr_upd, 1'b1);
	endtask

	task automatic t_stack;
		stack_limit_reg_wr = 1;
		stack_limit_reg_wdata = 16'h0A01;
		sp_wr = 1;
		sp_wdata = 16'h09FE;
		go(0);
		chk("stack_limit_reg", stack_limit_reg, 16'h0A00);
		idle();
		xset(1, 0, 0, SRC_PUSH, PTR_SP, AM_PLAIN, 16'h0000);
		x_pc_push = 1;
		x_wdata = 16'hFF12;
		go(1);
		chk("mem_addr", mem_addr, 15'h04FF);
		chk("mem_wdata", mem_wdata, 16'h0012);
		x_exc_push = 1;
		status_low_byte = 8'hC3;
		x_wdata = 16'h0034;
		go(1);
		chk("mem_wdata", mem_wdata, 16'hC334);
		chk("sp", stack_pointer_reg, 16'h0A02);
		chk("stack_err_trap", stack_err_trap, 1'b0);
		x_pc_push = 0;
		x_exc_push = 0;
		x_wdata = 16'h7777;
		go(1);
		chk("stack_err_trap", stack_err_trap, 1'b1);
		chk("trap_addr", trap_addr, 16'h0A02);
		xset(0, 0, 0, SRC_POP, PTR_SP, AM_PLAIN, 16'h0000);
		go(1);
		chk("stack_err_trap", stack_err_trap, 1'b0);
		chk("mem_addr", mem_addr, 15'h0501);
		chk("sp", stack_pointer_reg, 16'h0A02);
		idle();
		chk("x_rdata", x_rdata, 16'h7777);
		sp_wr = 1;
		sp_wdata = 16'h0800;
		go(0);
		sp_wr = 0;
		go(1);
		chk("stack_err_trap", stack_err_trap, 1'b1);
	endtask

	initial
	begin
		#40000;
		err_total++;
		close_out();
	end

	initial
	begin
		repeat (6) @(posedge clk);
		@(negedge clk);
		reset = 0;
		chk("sp", stack_pointer_reg, 16'h0800);
		chk("strobes", {mem_re, mem_we_lo, mem_we_hi, y_mem_re}, 4'h0);
		t_word_byte();
		t_align();
		t_spaces();
		t_modes();
		t_stack();
		close_out();
	end
endmodule
